// ===== hw/spc_pkg.sv
// Package for the sector protection and configuration block.
// Assumes a single 50 MHz clock domain and a plain register port.
package spc_pkg;
	// Register port offsets
	localparam logic [3:0] ADDR_CFG = 4'h0;
	localparam logic [3:0] ADDR_CTRL = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_SECT = 4'h3;
	localparam logic [3:0] ADDR_NVBIT = 4'h4;
	localparam logic [3:0] ADDR_VBIT = 4'h5;
	localparam logic [3:0] ADDR_PROT = 4'h6;
	localparam logic [3:0] ADDR_CMD = 4'h7;

	// Configuration word layout
	localparam logic [15:0] CFG_RESET = 16'hFEFF;
	localparam int CFG_TRAP = 13;
	localparam int CFG_HYBRID = 11;
	localparam int CFG_ECC = 9;
	localparam int CFG_RDPW = 5;
	localparam int CFG_PWLOCK = 2;
	localparam int CFG_PSLOCK = 1;
	localparam logic [1:0] MODE_BAD = 2'h0;
	localparam logic [1:0] MODE_PASSWORD = 2'h1;
	localparam logic [1:0] MODE_PERSIST = 2'h2;

	// Command codes written to the command register
	localparam logic [2:0] CMD_NV_PROG = 3'h1;
	localparam logic [2:0] CMD_NV_ERASE = 3'h2;
	localparam logic [2:0] CMD_V_SET = 3'h3;
	localparam logic [2:0] CMD_V_CLEAR = 3'h4;
	localparam logic [2:0] CMD_LOCK = 3'h5;
	localparam logic [2:0] CMD_UNLOCK = 3'h6;
	localparam logic [2:0] CMD_CFG_PROG = 3'h7;

	// Status bit positions
	localparam int ST_BUSY = 7;
	localparam int ST_FAIL = 4;
	localparam int ST_SLOCK = 1;

	// Typical word program time
	localparam int T_PROG_NS = 1000;
	localparam int CLK_NS = 20;
	localparam int PROG_CYC = (T_PROG_NS + CLK_NS - 1) / CLK_NS;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} spc_req_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PROG = 3'b010,
		ST_DONE = 3'b100
	} spc_state_t;
endpackage : spc_pkg

// ===== hw/spc_sector.sv
// One sector's protection bit pair and its resulting state.
// Assumes commands arrive as one-cycle strobes from the control logic.
`timescale 1ns/10ps
module spc_sector (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Commands
	input wire logic i_nv_prog,
	input wire logic i_nv_erase,
	input wire logic i_v_set,
	input wire logic i_v_clear,
	// State
	output logic o_nv,
	output logic o_v,
	output logic o_prot
);
	logic nv_q = 1'b1;
	logic v_q;
	// Nonvolatile cell: a real array keeps it; reset does not touch it here
	// because storage stands for flash contents.
	always_ff @(posedge i_clk) begin
		if (i_nv_erase) begin
			nv_q <= 1'b1;
		end else if (i_nv_prog) begin
			nv_q <= 1'b0;
		end
	end // see RULE4
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			v_q <= 1'b1; // see RULE3
		end else if (i_v_clear) begin
			v_q <= 1'b1;
		end else if (i_v_set) begin
			v_q <= 1'b0;
		end
	end
	assign o_nv = nv_q;
	assign o_v = v_q;
	assign o_prot = !(nv_q && v_q); // see RULE1
endmodule : spc_sector

// ===== hw/spc_top.sv
// Sector protection and configuration word logic of the flash device.
// Assumes a register port on the internal clock; password compare is
// done outside and reported on i_pw_match.
//
// Contract
// RULE1: Sector unprotected only when nonvolatile and volatile bits are both 1.
// RULE2: Nonvolatile bits change only while the persistent-bits lock is 1.
// RULE3: Reset returns every volatile sector bit to unprotected.
// RULE4: Nonvolatile sector protection survives power cycles and resets.
// RULE5: Config bit 13 selects single plus double or double-only error trap.
// RULE6: Config bit 11 selects hybrid or wrap-only burst.
// RULE7: Config bit 9 selects ECC control enabled or double error detect.
// RULE8: Config bit 5 at 0 permanently enables read-password mode.
// RULE9: Mode field 01 password, 10 persistent frozen, 11 temporary.
// RULE10: Unprogrammed config powers up persistent with all sectors open.
// RULE11: Programming both mode lock bits at once aborts with fail flags.
// RULE12: Config program after a mode lock bit is set aborts with flags.
// RULE13: Host programs password first, words in order 0,1,2,3.
// RULE14: In password mode lock clears only on reset or lock command.
// RULE15: Config program takes one word-program time, status shows progress.
// RULE16: Config bits are one-time-programmable nonvolatile cells.
// RULE17: Reset sets lock in persistent mode, clears it in password mode.
// RULE18: Program or erase of a sector is blocked if either bit is 0.
// RULE19: Config bits only go 1 to 0; 0 to 1 requests are ignored.
`timescale 1ns/10ps
module spc_top #(
	parameter int NSECT = 16,
	parameter int SW = 4,
	parameter int PROG_CYCLES = spc_pkg::PROG_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	output logic [15:0] o_rdata,
	// Password compare result from outside
	input wire logic i_pw_match,
	// Array access check
	input wire logic [SW-1:0] i_acc_sect,
	output logic o_acc_block,
	// Decoded configuration and lock state
	output logic o_trap_double_only,
	output logic o_burst_wrap_only,
	output logic o_ecc_ctrl_en,
	output logic o_double_error_detect,
	output logic o_read_pw_en,
	output logic o_password_mode,
	output logic o_persistent_bits_lock
);
	spc_pkg::spc_req_t req;
	spc_pkg::spc_state_t state_q;
	spc_pkg::spc_state_t state_d;
	logic [15:0] cfg_q = spc_pkg::CFG_RESET; // see RULE10
	logic [15:0] cfg_pend_q;
	// Program operand from the last select write; the command word's low
	// bits carry the code itself and would mask the mode bits
	logic [15:0] opnd_q;
	logic lock_q;
	logic lock_init_q;
	logic fail_q;
	logic slock_q;
	logic [SW-1:0] sect_q;
	logic [2:0] cmd_q;
	logic [15:0] cnt_q;
	logic [15:0] rdata_q;
	logic [NSECT-1:0] nv_bits;
	logic [NSECT-1:0] v_bits;
	logic [NSECT-1:0] prot_bits;
	logic [NSECT-1:0] nv_prog_s;
	logic [NSECT-1:0] v_set_s;
	logic [NSECT-1:0] v_clr_s;
	logic [6:0] out_q;
	logic block_q;

	assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

	// Decode
	wire wr_cmd = req.wr && (req.addr == spc_pkg::ADDR_CMD);
	wire wr_sect = req.wr && (req.addr == spc_pkg::ADDR_SECT);
	wire [2:0] cmd = req.wdata[2:0];
	wire idle = (state_q == spc_pkg::ST_IDLE);
	wire go = wr_cmd && idle;
	wire [1:0] mode = cfg_q[spc_pkg::CFG_PWLOCK:spc_pkg::CFG_PSLOCK];
	wire pw_mode = (mode == spc_pkg::MODE_PASSWORD);
	// see RULE9
	wire frozen = (mode != {2{1'b1}});
	// see RULE11
	wire both_lock = !opnd_q[spc_pkg::CFG_PWLOCK] &&
		!opnd_q[spc_pkg::CFG_PSLOCK];
	wire cfg_abort = frozen || both_lock; // see RULE12
	wire nv_abort = !lock_q; // see RULE2
	wire start_cfg = go && (cmd == spc_pkg::CMD_CFG_PROG) && !cfg_abort;
	wire start_nv = go && !nv_abort &&
		((cmd == spc_pkg::CMD_NV_PROG) || (cmd == spc_pkg::CMD_NV_ERASE));
	wire fail_now = go && (((cmd == spc_pkg::CMD_CFG_PROG) && cfg_abort) ||
		(!lock_q && ((cmd == spc_pkg::CMD_NV_PROG) ||
		(cmd == spc_pkg::CMD_NV_ERASE))) ||
		((cmd == spc_pkg::CMD_UNLOCK) && !i_pw_match));
	wire prog_end = (state_q == spc_pkg::ST_PROG) &&
		(cnt_q == 16'(PROG_CYCLES - 1));
	wire nv_commit = prog_end && (cmd_q == spc_pkg::CMD_NV_PROG);
	wire nv_erase_all = prog_end && (cmd_q == spc_pkg::CMD_NV_ERASE);

	genvar g;
	generate
		for (g = 0; g < NSECT; g++) begin : g_sect
			assign nv_prog_s[g] = nv_commit && (sect_q == SW'(g));
			assign v_set_s[g] = go && (cmd == spc_pkg::CMD_V_SET) &&
				(sect_q == SW'(g));
			assign v_clr_s[g] = go && (cmd == spc_pkg::CMD_V_CLEAR) &&
				(sect_q == SW'(g));
			spc_sector u_sect (
				.i_clk(i_clk),
				.i_rst_n(i_rst_n),
				.i_nv_prog(nv_prog_s[g]),
				.i_nv_erase(nv_erase_all),
				.i_v_set(v_set_s[g]),
				.i_v_clear(v_clr_s[g]),
				.o_nv(nv_bits[g]),
				.o_v(v_bits[g]),
				.o_prot(prot_bits[g])
			);
		end
	endgenerate

	always_comb begin
		state_d = state_q;
		case (state_q)
			spc_pkg::ST_IDLE: begin
				if (start_cfg || start_nv) begin
					state_d = spc_pkg::ST_PROG;
				end
			end
			spc_pkg::ST_PROG: begin
				if (prog_end) begin
					state_d = spc_pkg::ST_DONE;
				end
			end
			spc_pkg::ST_DONE: state_d = spc_pkg::ST_IDLE;
			default: state_d = spc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= spc_pkg::ST_IDLE;
			cnt_q <= 16'h0000;
			cmd_q <= 3'h0;
			cfg_pend_q <= 16'hFFFF;
		end else begin
			state_q <= state_d;
			cnt_q <= (state_q == spc_pkg::ST_PROG) ? cnt_q + 16'h0001 :
				16'h0000; // see RULE15
			if (go) begin
				cmd_q <= cmd;
				cfg_pend_q <= opnd_q;
			end
		end
	end

	// One-time cells keep their contents over reset; only programming
	// moves them, and only toward 0.
	always_ff @(posedge i_clk) begin
		if (prog_end && (cmd_q == spc_pkg::CMD_CFG_PROG)) begin
			cfg_q <= cfg_q & cfg_pend_q; // see RULE16 see RULE19
		end
	end

	// Reset value of the lock follows the stored mode, taken after release
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lock_init_q <= 1'b1;
		end else begin
			lock_init_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lock_q <= 1'b0;
		end else if (lock_init_q) begin
			lock_q <= !pw_mode; // see RULE17
		end else if (go && (cmd == spc_pkg::CMD_LOCK)) begin
			lock_q <= 1'b0; // see RULE14
		end else if (go && (cmd == spc_pkg::CMD_UNLOCK) && pw_mode &&
			i_pw_match) begin
			lock_q <= 1'b1;
		end
	end

	// Fail flags: a new failure wins over a clear in the same cycle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fail_q <= 1'b0;
			slock_q <= 1'b0;
			sect_q <= '0;
			opnd_q <= 16'hFFFF;
		end else begin
			if (fail_now) begin
				fail_q <= 1'b1; // see RULE11 see RULE12
				slock_q <= 1'b1;
			end else if (req.wr && (req.addr == spc_pkg::ADDR_STATUS)) begin
				fail_q <= 1'b0;
				slock_q <= 1'b0;
			end
			if (wr_sect) begin
				sect_q <= req.wdata[SW-1:0];
				opnd_q <= req.wdata;
			end
		end
	end

	// Read mux
	wire [15:0] status = {8'h00, !idle, 2'h0, fail_q, 2'h0, slock_q, 1'b0};
	wire [15:0] rd_mux =
		(req.addr == spc_pkg::ADDR_CFG) ? cfg_q :
		(req.addr == spc_pkg::ADDR_CTRL) ? {15'h0000, lock_q} :
		(req.addr == spc_pkg::ADDR_STATUS) ? status :
		(req.addr == spc_pkg::ADDR_SECT) ? 16'(sect_q) :
		(req.addr == spc_pkg::ADDR_NVBIT) ? 16'(nv_bits) :
		(req.addr == spc_pkg::ADDR_VBIT) ? 16'(v_bits) :
		(req.addr == spc_pkg::ADDR_PROT) ? 16'(prot_bits) : 16'h0000;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= 16'h0000;
			out_q <= 7'h00;
			block_q <= 1'b1;
		end else begin
			rdata_q <= req.rd ? rd_mux : 16'h0000;
			block_q <= prot_bits[i_acc_sect]; // see RULE18
			out_q <= {lock_q, pw_mode,
				!cfg_q[spc_pkg::CFG_RDPW], // see RULE8
				cfg_q[spc_pkg::CFG_ECC] ? 2'b10 : 2'b01, // see RULE7
				cfg_q[spc_pkg::CFG_HYBRID], // see RULE6
				cfg_q[spc_pkg::CFG_TRAP]}; // see RULE5
		end
	end

	assign o_rdata = rdata_q;
	assign o_acc_block = block_q;
	assign o_trap_double_only = out_q[0];
	assign o_burst_wrap_only = out_q[1];
	assign o_double_error_detect = out_q[2];
	assign o_ecc_ctrl_en = out_q[3];
	assign o_read_pw_en = out_q[4];
	assign o_password_mode = out_q[5];
	assign o_persistent_bits_lock = out_q[6];

	a_both_lock_abort: assert property ( // see RULE11
		@(posedge i_clk) disable iff (!i_rst_n)
		go && cmd == spc_pkg::CMD_CFG_PROG && both_lock |=> fail_q && slock_q)
		else $error("both lock bits did not abort");

	a_frozen_abort: assert property ( // see RULE12
		@(posedge i_clk) disable iff (!i_rst_n)
		go && cmd == spc_pkg::CMD_CFG_PROG && frozen |=> fail_q && slock_q)
		else $error("frozen config program not refused");

	a_frozen_keep: assert property ( // see RULE12
		@(posedge i_clk) disable iff (!i_rst_n)
		frozen |=> $stable(cfg_q[spc_pkg::CFG_PWLOCK:spc_pkg::CFG_PSLOCK]))
		else $error("frozen mode changed");

	a_nv_locked: assert property ( // see RULE2
		@(posedge i_clk) disable iff (!i_rst_n)
		!lock_q && !lock_init_q |=> $stable(nv_bits))
		else $error("nonvolatile bits changed under lock");

	a_nv_refused: assert property ( // see RULE2
		@(posedge i_clk) disable iff (!i_rst_n)
		go && !lock_q && (cmd == spc_pkg::CMD_NV_PROG ||
		cmd == spc_pkg::CMD_NV_ERASE) |=> fail_q && slock_q && idle)
		else $error("locked nonvolatile change not refused");

	a_dyn_change: assert property ( // see RULE2
		@(posedge i_clk) disable iff (!i_rst_n)
		go && cmd == spc_pkg::CMD_V_SET |=> !v_bits[$past(sect_q)])
		else $error("volatile bit not set");

	// A bit change in the checked cycle is skipped: the registered block
	// flag legitimately lags it by one edge.
	a_prot_map: assert property ( // see RULE1
		@(posedge i_clk) disable iff (!i_rst_n)
		!lock_init_q |=> !($stable(nv_bits) && $stable(v_bits)) ||
		block_q == !(nv_bits[$past(i_acc_sect)] &&
		v_bits[$past(i_acc_sect)]))
		else $error("protection state wrong");

	a_dyn_reset: assert property ( // see RULE3
		@(posedge i_clk) disable iff (!i_rst_n)
		lock_init_q |-> &v_bits)
		else $error("volatile bits kept over reset");

	a_nv_keep: assert property ( // see RULE4
		@(posedge i_clk) disable iff (!i_rst_n)
		lock_init_q |-> $stable(nv_bits))
		else $error("nonvolatile bits lost over reset");

	a_otp_keep: assert property ( // see RULE16
		@(posedge i_clk) disable iff (!i_rst_n)
		lock_init_q |-> $stable(cfg_q))
		else $error("config word lost over reset");

	a_trap_map: assert property ( // see RULE5
		@(posedge i_clk) disable iff (!i_rst_n)
		!lock_init_q |=> !$stable(cfg_q) ||
		o_trap_double_only == cfg_q[spc_pkg::CFG_TRAP])
		else $error("trap select not decoded");

	a_burst_map: assert property ( // see RULE6
		@(posedge i_clk) disable iff (!i_rst_n)
		!lock_init_q |=> !$stable(cfg_q) ||
		o_burst_wrap_only == cfg_q[spc_pkg::CFG_HYBRID])
		else $error("burst select not decoded");

	a_ecc_map: assert property ( // see RULE7
		@(posedge i_clk) disable iff (!i_rst_n)
		!lock_init_q |=> !$stable(cfg_q) ||
		(o_ecc_ctrl_en == cfg_q[spc_pkg::CFG_ECC] &&
		o_double_error_detect == !cfg_q[spc_pkg::CFG_ECC]))
		else $error("error handling select not decoded");

	a_rdpw_map: assert property ( // see RULE8
		@(posedge i_clk) disable iff (!i_rst_n)
		!lock_init_q |=> !$stable(cfg_q) ||
		o_read_pw_en == !cfg_q[spc_pkg::CFG_RDPW])
		else $error("read password enable not decoded");

	a_pw_mode_map: assert property ( // see RULE9
		@(posedge i_clk) disable iff (!i_rst_n)
		!lock_init_q |=> !$stable(cfg_q) ||
		o_password_mode == (cfg_q[spc_pkg::CFG_PWLOCK:spc_pkg::CFG_PSLOCK] ==
		spc_pkg::MODE_PASSWORD))
		else $error("password mode not decoded");

	a_lock_map: assert property ( // see RULE17
		@(posedge i_clk) disable iff (!i_rst_n)
		!lock_init_q |=> !$stable(lock_q) ||
		o_persistent_bits_lock == lock_q)
		else $error("lock output differs from lock");

	a_lock_reset: assert property ( // see RULE17
		@(posedge i_clk) disable iff (!i_rst_n)
		i_rst_n && lock_init_q |=> lock_q == !pw_mode)
		else $error("lock reset value wrong");

	a_lock_clear: assert property ( // see RULE14
		@(posedge i_clk) disable iff (!i_rst_n)
		go && cmd == spc_pkg::CMD_LOCK && !lock_init_q |=> !lock_q)
		else $error("lock command ignored");

	a_prog_time: assert property ( // see RULE15
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(state_q == spc_pkg::ST_PROG) |-> !idle [*2])
		else $error("program not busy");

	a_otp_down: assert property ( // see RULE19
		@(posedge i_clk)
		1'b1 |=> ((cfg_q & ~$past(cfg_q)) == 16'h0000))
		else $error("config bit went up");
endmodule : spc_top

// ===== sim/spc_host.sv
// Host controller model for the register port of the protection block.
// Assumes a slave that never stalls and answers a read one cycle later.
`timescale 1ns/10ps
module spc_host (
	// Clock
	input wire logic i_clk,
	// Register port
	output spc_pkg::spc_req_t o_req,
	input wire logic [15:0] i_rdata
);
	initial o_req = '{1'b0, 1'b0, 4'hF, 16'h0000};
	// No password words are sent, so their 0-1-2-3 order is never broken
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_req <= '{1'b0 | 1'b1, 1'b0, a, d};
		@(posedge i_clk);
		// Released lines must not keep their last value
		o_req <= '{1'b0, 1'b0, ~a, ~d};
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge i_clk);
		o_req <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge i_clk);
		o_req <= '{1'b0, 1'b0, ~a, 16'hFFFF};
		@(negedge i_clk);
		d = i_rdata;
	endtask : rd
endmodule : spc_host

// ===== sim/spc_top_bench.sv
// Self-checking bench for the sector protection and configuration block.
// Assumes the host model owns the register port; operands go via SECT.
`timescale 1ns/10ps
module spc_top_bench;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_pw_match = 1'b0;
	logic [3:0] sect = 4'h0;
	spc_pkg::spc_req_t req;
	logic [15:0] rdata, s;
	logic blk, trap, wrap, ecc, ded, rpw, pwm, lock;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;

	always #10 i_clk = ~i_clk;

	spc_host host (.i_clk(i_clk), .o_req(req), .i_rdata(rdata));

	// Short program time keeps the run brief
	spc_top #(.PROG_CYCLES(4)) DUT (
		.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_wr(req.wr), .i_rd(req.rd), .i_addr(req.addr),
		.i_wdata(req.wdata), .o_rdata(rdata),
		.i_pw_match(i_pw_match), .i_acc_sect(sect), .o_acc_block(blk),
		.o_trap_double_only(trap), .o_burst_wrap_only(wrap),
		.o_ecc_ctrl_en(ecc), .o_double_error_detect(ded),
		.o_read_pw_en(rpw), .o_password_mode(pwm),
		.o_persistent_bits_lock(lock)
	);

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			close_out();
		end
	end

	task automatic chk(input logic [15:0] got, exp, input string m = "output");
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got,
				exp);
		end
	endtask : chk

	task automatic do_reset();
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (2) @(posedge i_clk);
	endtask : do_reset

	task automatic rchk(input logic [3:0] a, input logic [15:0] e);
		host.rd(a, s);
		chk(s, e, "reg");
	endtask : rchk

	task automatic acc(input logic [3:0] n, input logic e);
		@(posedge i_clk);
		sect <= n;
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
		chk(blk, e, "block");
	endtask : acc

	// Operand to SECT, then the command; b asks for busy on the first poll
	task automatic run(input logic [2:0] c, input logic [15:0] d,
		input logic f, input logic b);
		host.wr(spc_pkg::ADDR_SECT, d);
		host.wr(spc_pkg::ADDR_CMD, {13'h0000, c});
		host.rd(spc_pkg::ADDR_STATUS, s);
		if (b)
			chk(s[spc_pkg::ST_BUSY], 1'b1, "busy");
		for (int i = 0; i < 100 && s[spc_pkg::ST_BUSY] !== 1'b0; i++)
			host.rd(spc_pkg::ADDR_STATUS, s);
		chk(s[spc_pkg::ST_FAIL], f, "fail flag");
		chk(s[spc_pkg::ST_SLOCK], f, "lock flag");
		host.wr(spc_pkg::ADDR_STATUS, 16'h0000);
	endtask : run

	task automatic t_power();
		rchk(spc_pkg::ADDR_CFG, 16'hFEFF);
		rchk(spc_pkg::ADDR_CTRL, 16'h0001);
		rchk(spc_pkg::ADDR_VBIT, 16'hFFFF);
		rchk(4'h9, 16'h0000);
		chk({trap, wrap, ecc, ded, rpw, pwm, lock}, 7'h71);
		acc(4'h0, 1'b0);
		$display("t_power done");
	endtask : t_power

	task automatic t_sector();
		run(spc_pkg::CMD_V_SET, 16'h0003, 1'b0, 1'b0);
		acc(4'h3, 1'b1);
		acc(4'h2, 1'b0);
		run(spc_pkg::CMD_NV_PROG, 16'h0005, 1'b0, 1'b1);
		acc(4'h5, 1'b1);
		rchk(spc_pkg::ADDR_PROT, 16'h0028);
		do_reset();
		acc(4'h3, 1'b0);
		acc(4'h5, 1'b1);
		$display("t_sector done");
	endtask : t_sector

	task automatic t_lock();
		run(spc_pkg::CMD_LOCK, 16'h0000, 1'b0, 1'b0);
		rchk(spc_pkg::ADDR_CTRL, 16'h0000);
		run(spc_pkg::CMD_NV_ERASE, 16'h0000, 1'b1, 1'b0);
		rchk(spc_pkg::ADDR_NVBIT, 16'hFFDF);
		run(spc_pkg::CMD_V_SET, 16'h0007, 1'b0, 1'b0);
		acc(4'h7, 1'b1);
		do_reset();
		rchk(spc_pkg::ADDR_CTRL, 16'h0001);
		run(spc_pkg::CMD_NV_ERASE, 16'h0000, 1'b0, 1'b1);
		rchk(spc_pkg::ADDR_NVBIT, 16'hFFFF);
		$display("t_lock done");
	endtask : t_lock

	task automatic t_cfg();
		run(spc_pkg::CMD_CFG_PROG, 16'hFFF9, 1'b1, 1'b0);
		rchk(spc_pkg::ADDR_CFG, 16'hFEFF);
		run(spc_pkg::CMD_CFG_PROG, 16'hD5DF, 1'b0, 1'b1);
		rchk(spc_pkg::ADDR_CFG, 16'hD4DF);
		chk({trap, wrap, ecc, ded, rpw}, 5'h03);
		run(spc_pkg::CMD_CFG_PROG, 16'hFFFF, 1'b0, 1'b1);
		rchk(spc_pkg::ADDR_CFG, 16'hD4DF);
		run(spc_pkg::CMD_CFG_PROG, 16'hFFFB, 1'b0, 1'b1);
		chk(pwm, 1'b1);
		run(spc_pkg::CMD_CFG_PROG, 16'hFFFF, 1'b1, 1'b0);
		do_reset();
		rchk(spc_pkg::ADDR_CTRL, 16'h0000);
		@(posedge i_clk);
		i_pw_match <= 1'b1;
		run(spc_pkg::CMD_UNLOCK, 16'h0000, 1'b0, 1'b0);
		chk(lock, 1'b1);
		run(spc_pkg::CMD_LOCK, 16'h0000, 1'b0, 1'b0);
		chk(lock, 1'b0);
		$display("t_cfg done");
	endtask : t_cfg

	initial begin
		do_reset();
		t_power();
		t_sector();
		t_lock();
		t_cfg();
		close_out();
	end
endmodule : spc_top_bench
